// ===== logic/brctl_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "brctl_regs.svh"
module brctl_top (
    input  wire logic                     i_clk,
    input  wire logic                     i_sys_rst,
    input  wire logic                     i_is_upstream,
    input  wire logic                     i_cfg_wr,
    input  wire logic                     i_cfg_rd,
    input  wire brctl_pkg::brctl_ofs_t    i_cfg_addr,
    input  wire brctl_pkg::brctl_be_t     i_cfg_be,
    input  wire brctl_pkg::brctl_word_t   i_cfg_wdata,
    output brctl_pkg::brctl_word_t        o_cfg_rdata,
    output logic                          o_cfg_ack,
    input  wire brctl_pkg::brctl_word_t   i_pf_base_hi,
    input  wire logic [11:0]              i_pf_base_lo,
    input  wire logic [11:0]              i_pf_limit_lo,
    input  wire logic [3:0]               i_io_base_lo,
    input  wire logic [3:0]               i_io_limit_lo,
    input  wire logic                     i_int_pin_load,
    input  wire logic [7:0]               i_int_pin_val,
    input  wire logic                     i_mem_req,
    input  wire brctl_pkg::brctl_addr64_t i_mem_addr,
    output logic                          o_mem_vld,
    output logic                          o_mem_fwd,
    input  wire logic                     i_io_req,
    input  wire brctl_pkg::brctl_word_t   i_io_addr,
    output logic                          o_io_vld,
    output logic                          o_io_fwd_down,
    output logic                          o_io_fwd_up,
    input  wire logic                     i_sec_poison,
    output logic                          o_poison_report,
    input  wire logic                     i_sec_err_msg,
    output logic                          o_err_fwd,
    output logic                          o_link_hot_reset,
    output logic                          o_port_rst_n,
    output logic                          o_dn_all_rst
);
    import brctl_pkg::*;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    brctl_word_t   pf_limit_hi_r;
    logic [15:0]   io_base_hi_r;
    logic [15:0]   io_limit_hi_r;
    logic [7:0]    int_line_r;
    logic [7:0]    int_pin_r;
    brctl_word_t   bc_r;
    brctl_word_t   rdata_nxt;
    brctl_word_t   rdata_r;
    logic          ack_r;
    logic          hit_pf;
    logic          hit_io;
    logic          hit_cap;
    logic          hit_intr;
    logic          wr_pf;
    logic          wr_io;
    logic          wr_intr;

    // ------------------------------------------------------------------
    // address decode of config requests
    // ------------------------------------------------------------------
    assign hit_pf   = (i_cfg_addr == `BRCTL_OFS_PF_LIMIT_HI);
    assign hit_io   = (i_cfg_addr == `BRCTL_OFS_IO_HI);
    assign hit_cap  = (i_cfg_addr == `BRCTL_OFS_CAP);
    assign hit_intr = (i_cfg_addr == `BRCTL_OFS_INTR);
    assign wr_pf    = i_cfg_wr && hit_pf;
    assign wr_io    = i_cfg_wr && hit_io;
    assign wr_intr  = i_cfg_wr && hit_intr;

    // prefetchable limit upper dword, byte-lane writes
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            pf_limit_hi_r <= `BRCTL_RST_PF_LIMIT_HI;
        end else if (wr_pf) begin
            for (int b = 0; b < 4; b++) begin
                if (i_cfg_be[b]) begin
                    pf_limit_hi_r[b*8 +: 8] <= i_cfg_wdata[b*8 +: 8];
                end
            end
        end
    end

    // i/o base upper half in bytes 0-1
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            io_base_hi_r <= `BRCTL_RST_IO_HI;
        end else if (wr_io) begin
            if (i_cfg_be[0]) begin
                io_base_hi_r[7:0] <= i_cfg_wdata[7:0];
            end
            if (i_cfg_be[1]) begin
                io_base_hi_r[15:8] <= i_cfg_wdata[15:8];
            end
        end
    end

    // i/o limit upper half in bytes 2-3
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            io_limit_hi_r <= `BRCTL_RST_IO_HI;
        end else if (wr_io) begin
            if (i_cfg_be[2]) begin
                io_limit_hi_r[7:0] <= i_cfg_wdata[23:16];
            end
            if (i_cfg_be[3]) begin
                io_limit_hi_r[15:8] <= i_cfg_wdata[31:24];
            end
        end
    end

    // interrupt line, plain storage for software
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            int_line_r <= `BRCTL_RST_INT_LINE;
        end else if (wr_intr && i_cfg_be[0]) begin
            int_line_r <= i_cfg_wdata[7:0];
        end
    end

    // interrupt pin, loadable only on a downstream port, never by config
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            int_pin_r <= `BRCTL_RST_INT_PIN;
        end else if (i_int_pin_load && !i_is_upstream) begin
            int_pin_r <= i_int_pin_val;
        end
    end

    // bridge control, only bits 16-20 and 22 are writable
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            bc_r <= `BRCTL_RST_BC;
        end else if (wr_intr && i_cfg_be[2]) begin
            bc_r <= {8'h00, i_cfg_wdata[23:16] & `BRCTL_BC_WR_MASK, 16'h0000};
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    // read mux, unmapped offsets read as zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (1'b1)
            hit_pf:   rdata_nxt = pf_limit_hi_r;
            hit_io:   rdata_nxt = {io_limit_hi_r, io_base_hi_r};
            hit_cap:  rdata_nxt = {24'h00_0000, `BRCTL_CAP_PTR_VAL};
            hit_intr: rdata_nxt = {bc_r[31:16], int_pin_r, int_line_r};
            default:  rdata_nxt = 32'h0000_0000;
        endcase
    end

    // registered read data and one-cycle acknowledge
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            rdata_r <= 32'h0000_0000;
            ack_r   <= 1'b0;
        end else begin
            ack_r <= i_cfg_wr || i_cfg_rd;
            if (i_cfg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign o_cfg_rdata = rdata_r;
    assign o_cfg_ack   = ack_r;

    // ------------------------------------------------------------------
    // forwarding decode
    // ------------------------------------------------------------------
    brctl_addr64_t pf_base;
    brctl_addr64_t pf_limit;
    brctl_word_t   io_base;
    brctl_word_t   io_limit;
    logic          mem_fwd_c;
    logic          mem_vga_c;
    logic          io_down_c;
    logic          io_up_c;

    // full window bounds from upper and lower halves
    assign pf_base  = {i_pf_base_hi, i_pf_base_lo, 20'h0_0000};
    assign pf_limit = {pf_limit_hi_r, i_pf_limit_lo, 20'hf_ffff};
    assign io_base  = {io_base_hi_r, i_io_base_lo, 12'h000};
    assign io_limit = {io_limit_hi_r, i_io_limit_lo, 12'hfff};

    brctl_mem_decode u_mem_dec (
        .i_vga_en  (bc_r[`BRCTL_BC_VGA]),
        .i_addr    (i_mem_addr),
        .i_base    (pf_base),
        .i_limit   (pf_limit),
        .o_fwd     (mem_fwd_c),
        .o_vga_hit (mem_vga_c)
    );

    brctl_io_decode u_io_dec (
        .i_isa_en   (bc_r[`BRCTL_BC_ISA]),
        .i_vga_en   (bc_r[`BRCTL_BC_VGA]),
        .i_vga16    (bc_r[`BRCTL_BC_VGA16]),
        .i_addr     (i_io_addr),
        .i_base     (io_base),
        .i_limit    (io_limit),
        .o_fwd_down (io_down_c),
        .o_fwd_up   (io_up_c)
    );

    // memory decision, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_mem_vld <= 1'b0;
            o_mem_fwd <= 1'b0;
        end else begin
            o_mem_vld <= i_mem_req;
            o_mem_fwd <= i_mem_req && mem_fwd_c;
        end
    end

    // i/o decision, one cycle after the request
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_io_vld      <= 1'b0;
            o_io_fwd_down <= 1'b0;
            o_io_fwd_up   <= 1'b0;
        end else begin
            o_io_vld      <= i_io_req;
            o_io_fwd_down <= i_io_req && io_down_c;
            o_io_fwd_up   <= i_io_req && io_up_c;
        end
    end

    // ------------------------------------------------------------------
    // secondary side events and resets
    // ------------------------------------------------------------------
    // poison reporting and error forwarding gates
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_poison_report <= 1'b0;
            o_err_fwd       <= 1'b0;
        end else begin
            o_poison_report <= i_sec_poison && bc_r[`BRCTL_BC_POISON];
            o_err_fwd       <= i_sec_err_msg && bc_r[`BRCTL_BC_ERR_FWD];
        end
    end

    // secondary bus reset fan-out, held while the bit stays set
    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_link_hot_reset <= 1'b0;
            o_port_rst_n     <= 1'b1;
            o_dn_all_rst     <= 1'b0;
        end else begin
            o_link_hot_reset <= bc_r[`BRCTL_BC_SBR];
            o_port_rst_n     <= !(bc_r[`BRCTL_BC_SBR] && !i_is_upstream);
            o_dn_all_rst     <= bc_r[`BRCTL_BC_SBR] && i_is_upstream;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    pf_limit_write_a: assert property (
        (wr_pf && i_cfg_be == 4'hf) |=> (pf_limit_hi_r == $past(i_cfg_wdata)))
        else $error("prefetch limit upper word not written");
    io_base_write_a: assert property (
        (wr_io && i_cfg_be[1:0] == 2'h3) |=> (io_base_hi_r == $past(i_cfg_wdata[15:0])))
        else $error("io base upper half not written");
    io_limit_write_a: assert property (
        (wr_io && i_cfg_be[3:2] == 2'h3) |=> (io_limit_hi_r == $past(i_cfg_wdata[31:16])))
        else $error("io limit upper half not written");
    cap_ptr_read_a: assert property (
        (i_cfg_rd && hit_cap) |=> (o_cfg_ack && o_cfg_rdata == 32'h0000_0040))
        else $error("capability pointer misread");
    int_pin_hold_a: assert property (
        (!i_int_pin_load || i_is_upstream) |=> $stable(int_pin_r))
        else $error("interrupt pin changed without a load");
    poison_gate_a: assert property (
        o_poison_report |-> $past(i_sec_poison && bc_r[`BRCTL_BC_POISON]))
        else $error("poison report without enable");
    err_fwd_gate_a: assert property (
        (i_sec_err_msg && bc_r[`BRCTL_BC_ERR_FWD]) |=> o_err_fwd)
        else $error("enabled error message not forwarded");
    isa_upstream_a: assert property (
        (i_io_req && bc_r[`BRCTL_BC_ISA] && io_up_c) |=> (o_io_fwd_up && !o_io_fwd_down))
        else $error("isa hole not sent upstream");
    vga_mem_off_a: assert property (
        (i_mem_req && !bc_r[`BRCTL_BC_VGA]
         && i_mem_addr >= `BRCTL_VGA_MEM_LO && i_mem_addr <= `BRCTL_VGA_MEM_HI
         && !(i_mem_addr >= pf_base && i_mem_addr <= pf_limit)) |=> !o_mem_fwd)
        else $error("vga memory forwarded while vga disabled");
    vga_io_fwd_a: assert property (
        (i_io_req && bc_r[`BRCTL_BC_VGA] && i_io_addr[31:10] == 22'h0
         && i_io_addr[9:0] >= 10'h3c0 && i_io_addr[9:0] <= 10'h3df) |=> o_io_fwd_down)
        else $error("vga io access not forwarded");
    vga16_alias_a: assert property (
        (i_io_req && bc_r[`BRCTL_BC_VGA16] && i_io_addr[15:10] != 6'h00
         && (!(i_io_addr >= io_base && i_io_addr <= io_limit)
             || (bc_r[`BRCTL_BC_ISA] && i_io_addr[31:16] == 16'h0000
                 && i_io_addr[9:0] >= `BRCTL_ISA_HOLE_LO))) |=> !o_io_fwd_down)
        else $error("16-bit vga decode let an alias through");
    hot_reset_dn_a: assert property (
        (bc_r[`BRCTL_BC_SBR] && !i_is_upstream) [*2] |-> (!o_port_rst_n && o_link_hot_reset))
        else $error("downstream port reset not driven");
    hot_reset_up_a: assert property (
        ($rose(bc_r[`BRCTL_BC_SBR]) && i_is_upstream) |=> o_dn_all_rst)
        else $error("upstream reset not fanned out");
    bc_zero_bits_a: assert property (
        (bc_r[31:23] == 9'h000) && !bc_r[21] && (bc_r[15:0] == 16'h0000))
        else $error("hardwired bridge control bit set");
    int_line_a: assert property (
        (wr_intr && i_cfg_be[0]) |=> (int_line_r == $past(i_cfg_wdata[7:0])))
        else $error("interrupt line not stored");
    pf_window_a: assert property (
        (i_mem_req && i_mem_addr == pf_limit) |=> o_mem_fwd)
        else $error("prefetch window limit not inclusive");

    hot_reset_c: cover property ($rose(o_link_hot_reset));
    isa_up_c: cover property (o_io_fwd_up);
    vga_mem_c: cover property (i_mem_req && mem_vga_c);
    err_fwd_c: cover property (o_err_fwd);
endmodule
`default_nettype wire

// ===== logic/brctl_regs.svh
`ifndef BRCTL_REGS_SVH
`define BRCTL_REGS_SVH
// ----------------------------------------------------------------------
// register offsets (byte addresses of config dwords)
// ----------------------------------------------------------------------
`define BRCTL_OFS_PF_LIMIT_HI 8'h2c
`define BRCTL_OFS_IO_HI       8'h30
`define BRCTL_OFS_CAP         8'h34
`define BRCTL_OFS_INTR        8'h3c
// ----------------------------------------------------------------------
// reset and fixed values
// ----------------------------------------------------------------------
`define BRCTL_RST_PF_LIMIT_HI 32'h0000_0000
`define BRCTL_RST_IO_HI       16'h0000
`define BRCTL_CAP_PTR_VAL     8'h40
`define BRCTL_RST_INT_LINE    8'h00
`define BRCTL_RST_INT_PIN     8'h00
`define BRCTL_RST_BC          32'h0000_0000
// ----------------------------------------------------------------------
// bridge control bit positions within the 3ch dword
// ----------------------------------------------------------------------
`define BRCTL_BC_POISON       16
`define BRCTL_BC_ERR_FWD      17
`define BRCTL_BC_ISA          18
`define BRCTL_BC_VGA          19
`define BRCTL_BC_VGA16        20
`define BRCTL_BC_SBR          22
`define BRCTL_BC_WR_MASK      8'h5f
// ----------------------------------------------------------------------
// address decode constants
// ----------------------------------------------------------------------
`define BRCTL_VGA_MEM_LO      64'h0000_0000_000a_0000
`define BRCTL_VGA_MEM_HI      64'h0000_0000_000b_ffff
`define BRCTL_VGA_IO_A_LO     10'h3b0
`define BRCTL_VGA_IO_A_HI     10'h3bb
`define BRCTL_VGA_IO_B_LO     10'h3c0
`define BRCTL_VGA_IO_B_HI     10'h3df
`define BRCTL_ISA_HOLE_LO     10'h100
`endif

// ===== logic/brctl_pkg.sv
`default_nettype none
package brctl_pkg;
    typedef logic [31:0] brctl_word_t;
    typedef logic [63:0] brctl_addr64_t;
    typedef logic [7:0]  brctl_ofs_t;
    typedef logic [3:0]  brctl_be_t;
endpackage
`default_nettype wire

// ===== logic/brctl_io_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "brctl_regs.svh"
module brctl_io_decode (
    input  wire logic               i_isa_en,
    input  wire logic               i_vga_en,
    input  wire logic               i_vga16,
    input  wire brctl_pkg::brctl_word_t i_addr,
    input  wire brctl_pkg::brctl_word_t i_base,
    input  wire brctl_pkg::brctl_word_t i_limit,
    output logic                    o_fwd_down,
    output logic                    o_fwd_up
);
    import brctl_pkg::*;
    logic in_win;
    logic low64k;
    logic isa_hole;
    logic vga_rng;
    logic vga_hit;
    // inclusive window compare on the full 32-bit address
    assign in_win   = (i_addr >= i_base) && (i_addr <= i_limit);
    assign low64k   = (i_addr[31:16] == 16'h0000);
    // top 768 bytes of every 1KB block in the first 64KB go upstream
    assign isa_hole = i_isa_en && low64k && (i_addr[9:0] >= `BRCTL_ISA_HOLE_LO);
    // vga legacy i/o ranges on the low ten bits
    assign vga_rng  = ((i_addr[9:0] >= `BRCTL_VGA_IO_A_LO) && (i_addr[9:0] <= `BRCTL_VGA_IO_A_HI))
                   || ((i_addr[9:0] >= `BRCTL_VGA_IO_B_LO) && (i_addr[9:0] <= `BRCTL_VGA_IO_B_HI));
    // 16-bit decode also checks bits 15:10, 10-bit decode lets aliases through
    assign vga_hit  = i_vga_en && low64k && vga_rng
                   && (!i_vga16 || (i_addr[15:10] == 6'h00));
    assign o_fwd_down = (in_win && !isa_hole) || vga_hit;
    assign o_fwd_up   = in_win && isa_hole && !vga_hit;
endmodule
`default_nettype wire

// ===== logic/brctl_mem_decode.sv
`timescale 1ns/100ps
`default_nettype none
`include "brctl_regs.svh"
module brctl_mem_decode (
    input  wire logic                    i_vga_en,
    input  wire brctl_pkg::brctl_addr64_t i_addr,
    input  wire brctl_pkg::brctl_addr64_t i_base,
    input  wire brctl_pkg::brctl_addr64_t i_limit,
    output logic                         o_fwd,
    output logic                         o_vga_hit
);
    import brctl_pkg::*;
    logic in_win;
    // inclusive 64-bit prefetchable window compare
    assign in_win    = (i_addr >= i_base) && (i_addr <= i_limit);
    // vga frame buffer range, ignored while vga forwarding is off
    assign o_vga_hit = i_vga_en && (i_addr >= `BRCTL_VGA_MEM_LO)
                    && (i_addr <= `BRCTL_VGA_MEM_HI);
    assign o_fwd     = in_win || o_vga_hit;
endmodule
`default_nettype wire

// ===== tb/brctl_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------
// config requester in the root complex's place
// --------------------------------------------
module brctl_host_model (
    input  wire logic                   i_clk,
    input  wire logic                   i_cfg_ack,
    input  wire brctl_pkg::brctl_word_t i_cfg_rdata,
    output logic                        o_cfg_wr,
    output logic                        o_cfg_rd,
    output brctl_pkg::brctl_ofs_t       o_cfg_addr,
    output brctl_pkg::brctl_be_t        o_cfg_be,
    output brctl_pkg::brctl_word_t      o_cfg_wdata
);
    import brctl_pkg::*;

    // idle bus at time zero
    initial begin
        o_cfg_wr    = 1'b0;
        o_cfg_rd    = 1'b0;
        o_cfg_addr  = 8'h00;
        o_cfg_be    = 4'h0;
        o_cfg_wdata = 32'h0000_0000;
    end

    // one access: request for one cycle, answer taken at the edge that sees ack high
    task automatic access(input logic wr, input brctl_ofs_t ofs, input brctl_be_t be,
                          input brctl_word_t wd, output logic ack, output brctl_word_t rd);
        @(posedge i_clk);
        o_cfg_wr    <= wr;
        o_cfg_rd    <= ~wr;
        o_cfg_addr  <= ofs;
        o_cfg_be    <= be;
        o_cfg_wdata <= wd;
        @(posedge i_clk);
        o_cfg_wr    <= 1'b0;
        o_cfg_rd    <= 1'b0;
        o_cfg_addr  <= ~ofs; // released address and data lines must not keep the last value
        o_cfg_wdata <= ~wd;
        @(posedge i_clk);
        ack = i_cfg_ack;
        rd  = i_cfg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== tb/brctl_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module brctl_top_bench;
    import brctl_pkg::*;
    // --------------------------------------------
    // stimulus, wiring and tables
    // --------------------------------------------
    logic clk = 1'b0, rst = 1'b1, upstream = 1'b0, pin_load = 1'b0;
    logic mem_req = 1'b0, io_req = 1'b0, poison = 1'b0, err_msg = 1'b0;
    logic [7:0] pin_val = 8'h00;
    brctl_addr64_t mem_addr = 64'h0;
    brctl_word_t io_addr = 32'h0, rd, cfg_rdata, cfg_wdata;
    logic cfg_wr, cfg_rd, cfg_ack, mem_vld, mem_fwd, io_vld, io_dn, io_up;
    logic poison_rep, err_fwd, link_rst, port_rst_n, dn_all_rst;
    brctl_ofs_t cfg_addr;
    brctl_be_t cfg_be;
    int bad_count = 0, num_checks = 0;
    brctl_ofs_t rofs [5] = '{8'h2c, 8'h30, 8'h34, 8'h3c, 8'h38};
    brctl_word_t rexp [5] = '{32'h0, 32'h0, 32'h40, 32'h0, 32'h0};
    brctl_ofs_t wofs [8] = '{8'h2c, 8'h2c, 8'h30, 8'h30, 8'h30, 8'h34, 8'h38, 8'h3c};
    brctl_be_t wbe [8] = '{4'hf, 4'he, 4'h3, 4'hc, 4'hf, 4'hf, 4'hf, 4'hf};
    brctl_word_t wdat [8] = '{32'h1234_5601, 32'h0, 32'hdead_beef, 32'hdead_beef, 32'h0,
                              32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};
    brctl_word_t wexp [8] = '{32'h1234_5601, 32'h0000_0001, 32'h0000_beef, 32'hdead_beef,
                              32'h0, 32'h0000_0040, 32'h0, 32'h005f_01ff};
    brctl_addr64_t mtab [8] = '{64'h1_1000_0000, 64'h1_0fff_ffff, 64'h1_1fff_ffff,
                                64'h1_2000_0000, 64'ha_0000, 64'hb_ffff, 64'hc_0000, 64'h9_ffff};
    logic mexp [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    brctl_word_t itab [8] = '{32'h0ff, 32'h100, 32'h3b0, 32'h7bb, 32'h3bc, 32'h3df,
                              32'h4ff, 32'h1_0000};
    logic [1:0] iexp [8] = '{2'b10, 2'b01, 2'b10, 2'b10, 2'b01, 2'b10, 2'b10, 2'b00};

    always #50 clk = ~clk;

    brctl_host_model host (.i_clk(clk), .i_cfg_ack(cfg_ack), .i_cfg_rdata(cfg_rdata),
        .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd), .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be),
        .o_cfg_wdata(cfg_wdata));

    brctl_top DUT (.i_clk(clk), .i_sys_rst(rst), .i_is_upstream(upstream),
        .i_cfg_wr(cfg_wr), .i_cfg_rd(cfg_rd), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be),
        .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack),
        .i_pf_base_hi(32'h0000_0001), .i_pf_base_lo(12'h100), .i_pf_limit_lo(12'h1ff),
        .i_io_base_lo(4'h0), .i_io_limit_lo(4'hf), .i_int_pin_load(pin_load),
        .i_int_pin_val(pin_val), .i_mem_req(mem_req), .i_mem_addr(mem_addr),
        .o_mem_vld(mem_vld), .o_mem_fwd(mem_fwd), .i_io_req(io_req), .i_io_addr(io_addr),
        .o_io_vld(io_vld), .o_io_fwd_down(io_dn), .o_io_fwd_up(io_up),
        .i_sec_poison(poison), .o_poison_report(poison_rep), .i_sec_err_msg(err_msg),
        .o_err_fwd(err_fwd), .o_link_hot_reset(link_rst), .o_port_rst_n(port_rst_n),
        .o_dn_all_rst(dn_all_rst));

    // --------------------------------------------
    // access and traffic tasks
    // --------------------------------------------
    task automatic cfg(input logic wr, input brctl_ofs_t ofs, input brctl_be_t be,
                       input brctl_word_t wd);
        logic ack;
        host.access(wr, ofs, be, wd, ack, rd);
        `CHK(ack, 1'b1)
    endtask

    // one cycle of decode traffic, results looked at while they stand
    task automatic decode(input brctl_addr64_t ma, input brctl_word_t ia, input logic ev);
        @(posedge clk);
        mem_req  <= 1'b1;
        io_req   <= 1'b1;
        mem_addr <= ma;
        io_addr  <= ia;
        poison   <= ev;
        err_msg  <= ev;
        @(posedge clk);
        mem_req  <= 1'b0;
        io_req   <= 1'b0;
        poison   <= 1'b0;
        err_msg  <= 1'b0;
        @(negedge clk);
        `CHK({mem_vld, io_vld}, 2'b11)
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // --------------------------------------------
    // test sequence
    // --------------------------------------------
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK({port_rst_n, link_rst, dn_all_rst}, 3'b100)
        for (int i = 0; i < 5; i++) begin
            cfg(1'b0, rofs[i], 4'h0, 32'h0);
            `CHK(rd, rexp[i])
        end
        @(posedge clk);
        pin_load <= 1'b1;
        pin_val  <= 8'h01;
        @(posedge clk);
        pin_load <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            cfg(1'b1, wofs[i], wbe[i], wdat[i]);
            cfg(1'b0, wofs[i], 4'h0, 32'h0);
            `CHK(rd, wexp[i])
        end
        `CHK({port_rst_n, link_rst, dn_all_rst}, 3'b010)
        @(posedge clk);
        upstream <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK({port_rst_n, dn_all_rst}, 2'b11)
        // an upstream port must ignore the pin load
        @(posedge clk);
        pin_load <= 1'b1;
        pin_val  <= 8'h02;
        @(posedge clk);
        pin_load <= 1'b0;
        cfg(1'b0, 8'h3c, 4'h0, 32'h0);
        `CHK(rd, 32'h005f_01ff)
        cfg(1'b1, 8'h3c, 4'h4, 32'h000f_0000);
        for (int i = 0; i < 8; i++) begin
            decode(mtab[i], itab[i], 1'b1);
            `CHK(mem_fwd, mexp[i])
            `CHK({io_dn, io_up}, iexp[i])
            `CHK({poison_rep, err_fwd}, 2'b11)
        end
        `CHK({dn_all_rst, link_rst}, 2'b00)
        cfg(1'b1, 8'h3c, 4'h4, 32'h001c_0000);
        decode(64'h0, 32'h7b0, 1'b1);
        `CHK({io_dn, io_up, poison_rep, err_fwd}, 4'b0100)
        decode(64'ha_0000, 32'h3b0, 1'b0);
        `CHK({mem_fwd, io_dn, io_up}, 3'b110)
        cfg(1'b1, 8'h3c, 4'h4, 32'h0000_0000);
        decode(64'ha_0000, 32'h3b0, 1'b0);
        `CHK({mem_fwd, io_dn, io_up}, 3'b010)
        complete_run();
    end

    // watchdog well beyond the hundred or so cycles the sequence needs
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
